/* logic/wdt_consts.svh */
// offsets, field positions, reset values and timing counts of the windowed watchdog
// ==========================================================================
// Operation
// - counter keeps running in sleep and idle
// - time-out in power save wakes, no reset
// - hard enable keeps watchdog always running
// - without hard enable, soft enable gates it
// - every device reset clears soft enable
// - time-out flag sticky until software clears
// - window disable zero selects windowed mode
// - prescaler divides by 32 or 128
// - postscaler sixteen ratios 1:1 to 1:32768
// - reset, switch, save, wake, clear outside power save zero counts
// - enabling watchdog enables the RC oscillator
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ==========================================================================
// timing
`define WDT_CLK_HZ      100000000
`define WDT_LOW_POWER_RC_OSC_HZ     32000
`define WDT_LOW_POWER_RC_OSC_DIV    (`WDT_CLK_HZ / `WDT_LOW_POWER_RC_OSC_HZ)
`define WDT_PRE_SHORT   32
`define WDT_PRE_LONG    128

// ==========================================================================
// register byte offsets
`define WDT_OFF_RESET_CONTROL_REG    8'h00
`define WDT_OFF_CFG     8'h04
`define WDT_OFF_ISTAT   8'h08
`define WDT_OFF_IMASK   8'h0C
`define WDT_OFF_COUNT   8'h10

// ==========================================================================
// reset_control_reg fields
`define WDT_RC_IDLE     2
`define WDT_RC_SLEEP    3
`define WDT_RC_TFLAG    4
`define WDT_RC_SOFT     5

// watchdog_config_word fields
`define WDT_CF_POST_LO  0
`define WDT_CF_PRE      4
`define WDT_CF_WINDOW_DISABLE   6
`define WDT_CF_HARD     7
`define WDT_CF_WSEL_LO  8

// interrupt status bits
`define WDT_IRQ_TIMEOUT 0
`define WDT_IRQ_WINDOW  1
`define WDT_IRQ_WAKE    2

// ==========================================================================
// reset values of the configuration word
`define WDT_RST_HARD    1'b0
`define WDT_RST_WINDOW_DISABLE  1'b1
`define WDT_RST_WSEL    2'h3
`define WDT_RST_PRE     1'b0
`define WDT_RST_POST    4'h0

`endif

/* logic/wdt_pkg.sv */
// types shared by the windowed watchdog
package wdt_pkg;

	// ======================================================================
	// operating state, gray along run -> power save -> run
	typedef enum logic [0:0]
	{
		ST_RUN  = 1'b0,
		ST_SAVE = 1'b1
	} wdt_state_t;

endpackage

/* logic/watchdog_timer_window.sv */
// windowed watchdog timer with prescaler, postscaler and avalon register slave
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "wdt_consts.svh"

module watchdog_timer_window
	import wdt_pkg::*;
#(
	parameter int LOW_POWER_RC_OSC_DIV = `WDT_LOW_POWER_RC_OSC_DIV	// system clocks per rc oscillator period
)
(
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	// avalon-mm slave
	input  wire logic [2:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [3:0]  byteenable_i,
	input  wire logic [31:0] writedata_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	// core events
	input  wire logic        clear_instr_i,
	input  wire logic        power_save_i,
	input  wire logic        sleep_mode_i,
	input  wire logic        wake_event_i,
	input  wire logic        clock_switch_done_i,
	// system outputs
	output logic             device_reset_o,
	output logic             wake_o,
	output logic             power_saving_o,
	output logic             low_power_rc_osc_enable_o,
	output logic             irq_o
);

	// ======================================================================
	// state
	typedef struct packed
	{
		wdt_state_t  state;		// run or power save
		logic [11:0] osc_cnt;	// rc oscillator period emulation
		logic [6:0]  pre;		// prescaler count
		logic [14:0] post;		// postscaler count
		logic        soft_en;	// software enable
		logic        sleep;		// entered sleep
		logic        idle;		// entered idle
		logic        tflag;		// time-out flag
		logic        hard_en;	// configuration hard enable
		logic        win_dis;	// window disable
		logic [1:0]  win_sel;	// window select
		logic        pre_sel;	// prescale select, 1 = divide by 128
		logic [3:0]  post_sel;	// postscale select
		logic [2:0]  irq_stat;	// sticky interrupt status
		logic [2:0]  irq_mask;	// interrupt mask
		logic        ack;		// bus cycle answered
		logic [31:0] rdata;		// read data
		logic        rst_pulse;	// device reset request
		logic        wake_pulse;	// wake request
	} wdt_regs_t;

	wdt_regs_t st;		// registered state
	wdt_regs_t next_st;	// next state

	// ======================================================================
	// helpers

	// postscaler period in prescaler ticks
	function automatic logic [15:0] post_period(input logic [3:0] sel);
		post_period = 16'h0001 << sel;
	endfunction

	// clear permitted: last quarter, 3/8, half or 3/4 of the period
	function automatic logic window_open(input logic [14:0] cnt, input logic [3:0] sel,
		input logic [1:0] wsel);
		logic [18:0] lhs;
		logic [18:0] rhs;
		logic [2:0]  closed;
		lhs = {cnt, 3'h0} + 19'h00008;
		case (wsel)
			2'h0:    closed = 3'h6;
			2'h1:    closed = 3'h5;
			2'h2:    closed = 3'h4;
			default: closed = 3'h2;
		endcase
		rhs = 19'(post_period(sel)) * 19'(closed);
		window_open = lhs > rhs;
	endfunction

	// byte-lane merge of a write
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = wd[i*8 +: 8];
		be_merge = res;
	endfunction

	// ======================================================================
	// derived signals
	logic        wd_en;		// watchdog running
	logic        osc_tick;	// one rc clock period elapsed
	logic        pre_last;	// prescaler at terminal count
	logic        post_last;	// postscaler at terminal count
	logic        timeout;	// time-out this cycle
	logic        bad_clear;	// clear outside the window
	logic [6:0]  pre_div;	// prescale ratio minus one
	logic [31:0] reset_control_reg_val;	// reset control view
	logic [31:0] cfg_val;	// configuration view
	logic        acc_ok;	// request accepted this edge

	// enable and terminal counts
	always_comb
	begin
		wd_en     = st.hard_en | st.soft_en;
		osc_tick  = wd_en && (st.osc_cnt == 12'(LOW_POWER_RC_OSC_DIV - 1));
		pre_div   = st.pre_sel ? 7'(`WDT_PRE_LONG - 1) : 7'(`WDT_PRE_SHORT - 1);
		pre_last  = st.pre == pre_div;
		// at or past the end, so a smaller ratio written mid-count still wraps
		post_last = {1'b0, st.post} >= post_period(st.post_sel) - 16'h0001;
		timeout   = osc_tick & pre_last & post_last;
		// windowed mode only when window disable is zero
		bad_clear = clear_instr_i && st.state == ST_RUN && wd_en && !st.win_dis
			&& !window_open(st.post, st.post_sel, st.win_sel);
		reset_control_reg_val  = 32'h00000000;
		reset_control_reg_val[`WDT_RC_IDLE]  = st.idle;
		reset_control_reg_val[`WDT_RC_SLEEP] = st.sleep;
		reset_control_reg_val[`WDT_RC_TFLAG] = st.tflag;
		reset_control_reg_val[`WDT_RC_SOFT]  = st.soft_en;
		cfg_val   = 32'h00000000;
		cfg_val[`WDT_CF_POST_LO +: 4] = st.post_sel;
		cfg_val[`WDT_CF_PRE]          = st.pre_sel;
		cfg_val[`WDT_CF_WINDOW_DISABLE]       = st.win_dis;
		cfg_val[`WDT_CF_HARD]         = st.hard_en;
		cfg_val[`WDT_CF_WSEL_LO +: 2] = st.win_sel;
		acc_ok    = (read_i | write_i) & st.ack;
	end

	// ======================================================================
	// next state
	always_comb
	begin
		logic [31:0] wr;
		logic        clr;
		wr  = 32'h00000000;
		clr = 1'b0;
		next_st = st;
		next_st.rst_pulse  = 1'b0;
		next_st.wake_pulse = 1'b0;

		// bus: one wait cycle, then answer
		next_st.ack = (read_i | write_i) & ~st.ack;
		if (read_i && !st.ack)
		begin
			case ({3'h0, address_i, 2'h0})
				`WDT_OFF_RESET_CONTROL_REG:  next_st.rdata = reset_control_reg_val;
				`WDT_OFF_CFG:   next_st.rdata = cfg_val;
				`WDT_OFF_ISTAT: next_st.rdata = {29'h0, st.irq_stat};
				`WDT_OFF_IMASK: next_st.rdata = {29'h0, st.irq_mask};
				`WDT_OFF_COUNT: next_st.rdata = {10'h000, st.pre, st.post};
				default:        next_st.rdata = 32'h00000000;	// unmapped reads zero
			endcase
		end

		// writes land first so hardware events below win
		if (acc_ok && write_i)
		begin
			case ({3'h0, address_i, 2'h0})
				`WDT_OFF_RESET_CONTROL_REG:
				begin
					wr = be_merge(reset_control_reg_val, writedata_i, byteenable_i);
					next_st.idle    = wr[`WDT_RC_IDLE];
					next_st.sleep   = wr[`WDT_RC_SLEEP];
					next_st.tflag   = wr[`WDT_RC_TFLAG];
					next_st.soft_en = wr[`WDT_RC_SOFT];
				end
				`WDT_OFF_CFG:
				begin
					wr = be_merge(cfg_val, writedata_i, byteenable_i);
					next_st.post_sel = wr[`WDT_CF_POST_LO +: 4];
					next_st.pre_sel  = wr[`WDT_CF_PRE];
					next_st.win_dis  = wr[`WDT_CF_WINDOW_DISABLE];
					next_st.hard_en  = wr[`WDT_CF_HARD];
					next_st.win_sel  = wr[`WDT_CF_WSEL_LO +: 2];
				end
				`WDT_OFF_ISTAT:
					if (byteenable_i[0])
						next_st.irq_stat = st.irq_stat & ~writedata_i[2:0];
				`WDT_OFF_IMASK:
					if (byteenable_i[0])
						next_st.irq_mask = writedata_i[2:0];
				default:
					next_st.irq_mask = st.irq_mask;	// unmapped writes ignored
			endcase
		end

		// counting runs in every state while enabled
		if (wd_en)
		begin
			next_st.osc_cnt = osc_tick ? 12'h000 : st.osc_cnt + 12'h001;
			if (osc_tick)
			begin
				next_st.pre = pre_last ? 7'h00 : st.pre + 7'h01;
				if (pre_last)
					next_st.post = post_last ? 15'h0000 : st.post + 15'h0001;
			end
		end
		else
		begin
			// disabled: held at zero, nothing accumulates
			next_st.osc_cnt = 12'h000;
			next_st.pre     = 7'h00;
			next_st.post    = 15'h0000;
		end

		// events
		case (st.state)
			ST_SAVE:
			begin
				if (timeout)
				begin
					// wake, resume after the power-save instruction
					next_st.wake_pulse = 1'b1;
					next_st.tflag      = 1'b1;
					next_st.state      = ST_RUN;
					next_st.irq_stat[`WDT_IRQ_WAKE] = 1'b1;
					clr = 1'b1;
				end
				else if (wake_event_i)
				begin
					next_st.state = ST_RUN;
					clr = 1'b1;
				end
			end
			ST_RUN:
			begin
				if (timeout || bad_clear)
				begin
					next_st.rst_pulse = 1'b1;
					next_st.tflag     = 1'b1;
					next_st.soft_en   = 1'b0;
					// set on top of any same-cycle clear, so the event wins
					if (timeout)
						next_st.irq_stat[`WDT_IRQ_TIMEOUT] = 1'b1;
					if (bad_clear)
						next_st.irq_stat[`WDT_IRQ_WINDOW] = 1'b1;
					clr = 1'b1;
				end
				else if (clear_instr_i)
					clr = 1'b1;
				else if (power_save_i)
				begin
					next_st.state = ST_SAVE;
					next_st.sleep = next_st.sleep | sleep_mode_i;
					next_st.idle  = next_st.idle | ~sleep_mode_i;
					clr = 1'b1;
				end
			end
			default:
				next_st.state = ST_RUN;
		endcase

		// a completed clock switch restarts the count too
		if (clr || clock_switch_done_i)
		begin
			next_st.osc_cnt = 12'h000;
			next_st.pre     = 7'h00;
			next_st.post    = 15'h0000;
		end
	end

	// ======================================================================
	// registers; reset zeroes counts and the soft enable
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			st          <= '0;
			st.state    <= ST_RUN;
			st.hard_en  <= `WDT_RST_HARD;
			st.win_dis  <= `WDT_RST_WINDOW_DISABLE;
			st.win_sel  <= `WDT_RST_WSEL;
			st.pre_sel  <= `WDT_RST_PRE;
			st.post_sel <= `WDT_RST_POST;
		end
		else
			st <= next_st;
	end

	// ======================================================================
	// outputs
	assign readdata_o     = st.rdata;
	assign waitrequest_o  = (read_i | write_i) & ~st.ack;
	assign device_reset_o = st.rst_pulse;
	assign wake_o         = st.wake_pulse;
	assign power_saving_o = st.state == ST_SAVE;
	assign low_power_rc_osc_enable_o  = wd_en;
	assign irq_o          = |(st.irq_stat & st.irq_mask);

	// ======================================================================
	// checks
	save_counts_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st.state == ST_SAVE && osc_tick && !timeout && !wake_event_i && !clock_switch_done_i)
		|=> st.pre != $past(st.pre))
		else $error("count stalled in power save");

	save_wake_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st.state == ST_SAVE && timeout)
		|=> wake_o && !device_reset_o && st.state == ST_RUN)
		else $error("power save time-out did not wake");

	hard_run_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st.hard_en && !osc_tick && !clear_instr_i && !power_save_i && !wake_event_i
		&& !clock_switch_done_i) |=> st.osc_cnt == $past(st.osc_cnt) + 12'h001)
		else $error("hard enable did not keep watchdog running");

	soft_gate_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(!st.hard_en && !st.soft_en) |=> (st.pre == 7'h00 && st.post == 15'h0000))
		else $error("disabled watchdog counted");

	reset_soft_a: assert property (@(posedge clock_i) disable iff (reset_i)
		device_reset_o |-> !st.soft_en && st.tflag)
		else $error("soft enable survived device reset");

	flag_sticky_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st.tflag && !(write_i && st.ack)) |=> st.tflag)
		else $error("time-out flag cleared by hardware");

	early_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(clear_instr_i && st.state == ST_RUN && wd_en && !st.win_dis
		&& !window_open(st.post, st.post_sel, st.win_sel)) |=> device_reset_o)
		else $error("early clear did not reset");

	open_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(clear_instr_i && st.state == ST_RUN && st.win_dis && !timeout)
		|=> !device_reset_o && st.pre == 7'h00)
		else $error("clear refused with window disabled");

	pre_range_a: assert property (@(posedge clock_i) disable iff (reset_i)
		st.pre <= (st.pre_sel ? 7'h7F : 7'h1F))
		else $error("prescaler out of range");

	post_range_a: assert property (@(posedge clock_i) disable iff (reset_i)
		({1'b0, st.post} < post_period(st.post_sel))
		|=> {1'b0, st.post} < post_period(st.post_sel) || $changed(st.post_sel))
		else $error("postscaler out of range");

	switch_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
		clock_switch_done_i |=> st.pre == 7'h00 && st.post == 15'h0000)
		else $error("clock switch did not clear counts");

	osc_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(st.soft_en && !$past(st.soft_en)) |-> low_power_rc_osc_enable_o)
		else $error("rc oscillator not enabled");

endmodule

/* verif/tb_watchdog_timer_window.sv */
// self-checking testbench for the windowed watchdog timer
module tb_watchdog_timer_window;
	timeunit 1ns;
	timeprecision 1ps;
	// ======================================================================
	// stimulus and observation signals
	localparam int L = 2;                // shortened rc divider keeps periods short
	logic        clock_i;                // 100 MHz system clock
	logic        reset_i;                // synchronous reset
	logic [2:0]  address_i;              // avalon word address
	logic        read_i, write_i;        // avalon strobes
	logic [3:0]  byteenable_i;           // write lanes
	logic [31:0] writedata_i, readdata_o;
	logic        waitrequest_o;
	logic        clear_instr_i, power_save_i, sleep_mode_i, wake_event_i, clock_switch_done_i;
	logic        device_reset_o, wake_o, power_saving_o, low_power_rc_osc_enable_o, irq_o;
	logic [31:0] read_q[$];              // expected read data, oldest first
	logic [31:0] ev_q[$];                // expected pulses: 1 reset, 2 wake
	int          miscompares, num_checks;
	logic [31:0] m;                      // random mask value
	logic        pre;                    // prescale select under test
	int          post;                   // postscale select under test

	watchdog_timer_window #(.LOW_POWER_RC_OSC_DIV(L)) i_watchdog_timer_window
	(
		.clock_i, .reset_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
		.readdata_o, .waitrequest_o, .clear_instr_i, .power_save_i, .sleep_mode_i,
		.wake_event_i, .clock_switch_done_i, .device_reset_o, .wake_o, .power_saving_o,
		.low_power_rc_osc_enable_o, .irq_o
	);

	// ======================================================================
	// clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// ======================================================================
	// helpers
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic close_out();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clock_i);
		read_i <= !wr;
		write_i <= wr;
		address_i <= a;
		writedata_i <= d;
		do @(posedge clock_i); while (waitrequest_o);
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [31:0] e);
		read_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// one-cycle core event: 0 clear, 1 clock switch, 2 power save, 3 wake source
	task automatic ev(input int k);
		@(posedge clock_i);
		case (k)
			0: clear_instr_i <= 1'b1;
			1: clock_switch_done_i <= 1'b1;
			2: power_save_i <= 1'b1;
			default: wake_event_i <= 1'b1;
		endcase
		@(posedge clock_i);
		{clear_instr_i, clock_switch_done_i, power_save_i, wake_event_i} <= 4'h0;
	endtask

	// level outputs are looked at mid-cycle, after the edge's updates
	task automatic lvl(input string nm, input logic e, input logic s);
		check(nm, {31'h0, e}, {31'h0, s});
	endtask

	// note the pulse kind; the pulse is seen one edge after the p-th edge
	task automatic wait_pulse(input logic [31:0] kind, input int p);
		int n;
		n = 0;
		ev_q.push_back(kind);
		do
		begin
			@(posedge clock_i);
			n++;
		end
		while (!(device_reset_o || wake_o) && n < p + 20);
		check("pulse delay", 32'(p + 1), 32'(n));
	endtask

	// ======================================================================
	// monitor: pairs every answer with the oldest note
	always @(posedge clock_i)
	begin
		if (read_i && !waitrequest_o)
			check("readdata", read_q.size() ? read_q.pop_front() : 32'hDEAD_BEEF, readdata_o);
		if (device_reset_o || wake_o)
			check("pulse kind", ev_q.size() ? ev_q.pop_front() : 32'hF,
				{30'h0, wake_o, device_reset_o});
	end

	// ======================================================================
	// hang guard, well beyond the few thousand cycles the tests need
	initial
	begin
		repeat (30000) @(posedge clock_i);
		miscompares++;
		close_out();
	end

	// ======================================================================
	// main sequence
	initial
	begin
		reset_i = 1'b1;
		{read_i, write_i, clear_instr_i, power_save_i, sleep_mode_i} = 5'h0;
		{wake_event_i, clock_switch_done_i} = 2'h0;
		address_i = 3'h0;
		writedata_i = 32'h0;
		byteenable_i = 4'hF;
		miscompares = 0;
		num_checks = 0;
		void'($urandom(67));
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		// reset values, unmapped place, idle watchdog
		rd(3'h1, 32'h0000_0340);
		rd(3'h0, 32'h0);
		wr(3'h5, 32'hFFFF_FFFF);
		rd(3'h5, 32'h0);
		repeat (200) @(posedge clock_i);
		rd(3'h4, 32'h0);
		@(negedge clock_i) lvl("low_power_rc_osc off", 1'b0, low_power_rc_osc_enable_o);
		// running time-outs over prescale and postscale choices
		for (int i = 0; i < 5; i++)
		begin
			pre = (i == 4);
			post = pre ? $urandom_range(1, 0) : i;
			wr(3'h1, 32'h0000_0340 | {27'h0, pre, post[3:0]});
			wr(3'h0, 32'h20);
			@(negedge clock_i) lvl("low_power_rc_osc on", 1'b1, low_power_rc_osc_enable_o);
			wait_pulse(32'h1, (L * (pre ? 128 : 32)) << post);
			rd(3'h0, 32'h10);
		end
		// interrupt: random mask over time-out status
		m = $urandom & 32'h7;
		wr(3'h3, m);
		@(negedge clock_i) lvl("irq", m[0], irq_o);
		rd(3'h3, m);
		wr(3'h2, 32'h7);
		rd(3'h2, 32'h0);
		@(negedge clock_i) lvl("irq clear", 1'b0, irq_o);
		repeat (300) @(posedge clock_i);
		rd(3'h0, 32'h10);
		wr(3'h0, 32'h0);
		// clear and clock switch restart the count
		wr(3'h1, 32'h0000_0340);
		wr(3'h0, 32'h20);
		for (int k = 0; k < 2; k++)
		begin
			repeat (40) @(posedge clock_i);
			ev(k);
		end
		wait_pulse(32'h1, 64);
		// device reset in mid-run drops the soft enable
		wr(3'h0, 32'h20);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		rd(3'h0, 32'h0);
		// hard enable overrides a cleared soft enable
		wr(3'h1, 32'h0000_03C0);
		wr(3'h0, 32'h0);
		@(negedge clock_i) lvl("low_power_rc_osc hard", 1'b1, low_power_rc_osc_enable_o);
		wait_pulse(32'h1, 61);
		wr(3'h1, 32'h0000_0340);
		rd(3'h0, 32'h10);
		// power save: time-out wakes instead of resetting
		for (int s = 0; s < 2; s++)
		begin
			wr(3'h0, 32'h20);
			sleep_mode_i <= s[0];
			ev(2);
			@(negedge clock_i) lvl("saving", 1'b1, power_saving_o);
			if (s == 1)
				ev(0);
			wait_pulse(32'h2, (s == 1) ? 62 : 64);
			@(negedge clock_i) lvl("woken", 1'b0, power_saving_o);
			rd(3'h0, (s == 1) ? 32'h38 : 32'h34);
			wr(3'h0, 32'h0);
		end
		// other wake source exits early and restarts the count
		sleep_mode_i <= 1'b0;
		wr(3'h0, 32'h20);
		ev(2);
		repeat (20) @(posedge clock_i);
		ev(3);
		@(negedge clock_i) lvl("exit", 1'b0, power_saving_o);
		wait_pulse(32'h1, 64);
		rd(3'h0, 32'h14);
		wr(3'h0, 32'h0);
		// windowed mode, final quarter open: late clear kept, early clear resets
		wr(3'h1, 32'h0000_0003);
		wr(3'h0, 32'h20);
		repeat (420) @(posedge clock_i);
		ev(0);
		repeat (300) @(posedge clock_i);
		ev(0);
		wait_pulse(32'h1, 0);
		rd(3'h0, 32'h10);
		// widest window (select 3): open from a quarter of the period on
		wr(3'h1, 32'h0000_0303);
		wr(3'h0, 32'h20);
		repeat (150) @(posedge clock_i);
		ev(0);
		repeat (60) @(posedge clock_i);
		ev(0);
		wait_pulse(32'h1, 0);
		rd(3'h0, 32'h10);
		rd(3'h2, 32'h7);
		close_out();
	end
endmodule
